// *** shared/cmd_consts.svh ***
// Constants for the counter mode decoder: register word indices, field
// positions, command bits, gate codes and reset values.
// Assumes a Wishbone slave that decodes byte address bits [7:2] as a word index.
`ifndef CMD_CONSTS_SVH
`define CMD_CONSTS_SVH

// Register word indices; the byte address is four times the index.
`define CMD_ADR_MODE     6'h00
`define CMD_ADR_LOAD     6'h01
`define CMD_ADR_HOLD     6'h02
`define CMD_ADR_COUNT    6'h03
`define CMD_ADR_COMMAND  6'h04
`define CMD_ADR_STATUS   6'h05

// Mode register field positions.
`define CMD_MODE_GATE_HI 15
`define CMD_MODE_GATE_LO 13
`define CMD_MODE_SPEC    7
`define CMD_MODE_REP     5

// Gate control field codes.
`define CMD_GATE_NONE    3'h0
`define CMD_GATE_LEVEL   3'h1
`define CMD_GATE_EDGE    3'h2

// Command register bits.
`define CMD_BIT_ARM      0
`define CMD_BIT_DISARM   1
`define CMD_BIT_LOAD     2
`define CMD_BIT_SAVE     3

// Reset values and the terminal count value.
`define CMD_WORD_RST     16'h0000
`define CMD_TC_VALUE     16'h0001

`endif

// *** shared/cmd_pkg.sv ***
// Types shared by the counter mode decoder files.
// Assumes the constants header is compiled alongside.
package cmd_pkg;

  // The six mode bits that select one lettered counter mode.
  typedef struct packed {
    logic [2:0] gate_control_field;
    logic       special_gate_bit;
    logic       reload_source_bit;
    logic       repetition_bit;
  } cmd_mode_t;

  // Arm state of the counter.
  typedef enum logic [1:0] {
    CMD_ST_IDLE = 2'b00,
    CMD_ST_WAIT = 2'b01,
    CMD_ST_RUN  = 2'b10
  } cmd_state_t;

  // Status word as software reads it.
  typedef struct packed {
    logic [9:0] zero;
    logic       reserved_mode;
    logic       gate_level;
    logic       phase;
    logic       at_tc;
    logic       running;
    logic       armed;
  } cmd_status_t;

endpackage : cmd_pkg

// *** design/cmd_pin_sync.sv ***
// Three-stage synchroniser with a settle filter for one pin input.
// Assumes the pin is asynchronous to clk_i; a change counts once stages two
// and three agree.
`timescale 1ns/10ps
module cmd_pin_sync
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o
);

  logic ff1_reg, ff2_reg, ff3_reg;
  logic level_reg, level_next;
  logic rise_reg, rise_next;

  // Only the second and third stages and the agreed level are looked at, never the first.
  always_comb
  begin
    level_next = level_reg;
    rise_next  = 1'b0;
    if (ff2_reg == ff3_reg)
    begin
      level_next = ff2_reg;
      rise_next  = ff2_reg && !level_reg; // Only the active-going change counts.
    end
  end

  // Register the chain and the filtered level.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ff1_reg   <= 1'b0;
      ff2_reg   <= 1'b0;
      ff3_reg   <= 1'b0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
    end
    else
    begin
      ff1_reg   <= pin_i;
      ff2_reg   <= ff1_reg;
      ff3_reg   <= ff2_reg;
      level_reg <= level_next;
      rise_reg  <= rise_next;
    end
  end

  assign level_o = level_reg;
  assign rise_o  = rise_reg;

endmodule : cmd_pin_sync

// *** design/cmd_counter_mode_decoder.sv ***
// One counter with its mode decoder, reached over a classic Wishbone slave.
// Assumes source and gate are asynchronous active-high pins and that the
// counter counts down on each active-going source edge.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "cmd_consts.svh"
module cmd_counter_mode_decoder
  import cmd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        source_i,
  input  wire logic        gate_i,
  output logic             tc_o
);

  cmd_mode_t   mode_reg, mode_next;
  cmd_state_t  state_reg, state_next;
  cmd_status_t status;
  logic [15:0] load_reg, load_next;
  logic [15:0] hold_reg, hold_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] reload_val;
  logic [31:0] dat_reg, dat_next;
  logic [5:0]  word;
  logic        phase_reg, phase_next;
  logic        ack_reg, ack_next;
  logic        tc_reg, tc_next;
  logic        src_lvl, src_rise, gate_lvl, gate_rise;
  logic        req, wr, cmd_wr, arm_cmd, disarm_cmd, load_cmd, save_cmd;
  logic        is_level, is_edge, reserved, once, twice, alternate;
  logic        retrig, capture_x, gate_sel, stop_edge, disarm_tc;
  logic        at_tc, eligible, take;

  // Both pins pass the settle filter; each gives its filtered level and a rising-edge pulse.
  cmd_pin_sync u_source_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (source_i),
    .level_o (src_lvl),
    .rise_o  (src_rise)
  );

  cmd_pin_sync u_gate_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (gate_i),
    .level_o (gate_lvl),
    .rise_o  (gate_rise)
  );

  // Bus decode; a request is answered one cycle after it is seen.
  assign req        = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr         = req && wb_we_i;
  assign word       = wb_adr_i[7:2];
  assign cmd_wr     = wr && (word == `CMD_ADR_COMMAND) && wb_sel_i[0];
  assign arm_cmd    = cmd_wr && wb_dat_i[`CMD_BIT_ARM];
  assign disarm_cmd = cmd_wr && wb_dat_i[`CMD_BIT_DISARM];
  assign load_cmd   = cmd_wr && wb_dat_i[`CMD_BIT_LOAD];
  assign save_cmd   = cmd_wr && wb_dat_i[`CMD_BIT_SAVE];

  // Mode decode from the six mode bits.
  assign is_level  = mode_reg.gate_control_field == `CMD_GATE_LEVEL;
  assign is_edge   = mode_reg.gate_control_field == `CMD_GATE_EDGE;
  assign once      = !mode_reg.repetition_bit && !mode_reg.reload_source_bit;
  assign twice     = !mode_reg.repetition_bit && mode_reg.reload_source_bit;
  assign alternate = !mode_reg.special_gate_bit && mode_reg.reload_source_bit;
  assign retrig    = mode_reg.special_gate_bit && !mode_reg.reload_source_bit;
  assign capture_x = mode_reg.special_gate_bit && mode_reg.reload_source_bit
                     && mode_reg.repetition_bit && is_edge;
  assign gate_sel  = mode_reg.special_gate_bit && mode_reg.reload_source_bit
                     && !capture_x;
  // Edge modes stop every terminal count, except I and L which stop on the second.
  assign stop_edge = is_edge && (mode_reg.special_gate_bit
                     || !mode_reg.reload_source_bit || phase_reg);
  assign disarm_tc = once || (twice && phase_reg);

  // Reserved combinations never count down, though an edge at terminal count still reloads; software is expected to avoid them.
  always_comb
  begin
    reserved = 1'b0;
    if (mode_reg.special_gate_bit)
    begin
      if (!mode_reg.reload_source_bit)
        reserved = !is_level && !is_edge;
      else if (!mode_reg.repetition_bit)
        reserved = is_level || is_edge;
      else
        reserved = is_level;
    end
  end

  // Reload source chosen at terminal count.
  always_comb
  begin
    reload_val = load_reg;
    if (alternate)
      reload_val = phase_reg ? load_reg : hold_reg;
    else if (gate_sel)
      reload_val = gate_lvl ? hold_reg : load_reg;
  end

  // A counter at terminal count always takes the edge; otherwise it must be eligible.
  assign at_tc    = count_reg == `CMD_TC_VALUE;
  assign eligible = (state_reg == CMD_ST_RUN) && !reserved
                    && (!is_level || gate_lvl);
  assign take     = src_rise && (at_tc || eligible);

  // Counter, hold register, arm state and alternation phase.
  always_comb
  begin
    count_next = count_reg;
    hold_next  = hold_reg;
    state_next = state_reg;
    phase_next = phase_reg;
    if (wr && (word == `CMD_ADR_HOLD))
    begin
      if (wb_sel_i[0])
        hold_next[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1])
        hold_next[15:8] = wb_dat_i[15:8];
    end
    if (save_cmd)
      hold_next = count_reg;
    if (load_cmd)
      count_next = load_reg;
    if (take)
    begin
      if (at_tc)
      begin
        // The edge leaving terminal count reloads and ends the cycle at once.
        count_next = reload_val;
        if (alternate || twice)
          phase_next = !phase_reg;
        if (disarm_tc)
          state_next = CMD_ST_IDLE;
        else if (stop_edge)
          state_next = CMD_ST_WAIT;
      end
      else
        count_next = count_reg - 16'h0001;
    end
    // Gate edges on a disarmed counter are dropped; a running one only retriggers or captures.
    case (state_reg)
      CMD_ST_IDLE:
      begin
        state_next = state_next;
      end
      CMD_ST_WAIT:
      begin
        if (gate_rise && !reserved)
        begin
          state_next = CMD_ST_RUN;
          if (retrig || capture_x)
            hold_next = count_reg;
          if (retrig)
            count_next = load_reg;
        end
      end
      CMD_ST_RUN:
      begin
        if (gate_rise && !reserved)
        begin
          if (retrig || capture_x)
            hold_next = count_reg;
          if (retrig)
            count_next = load_reg;
        end
      end
      default:
      begin
        state_next = CMD_ST_IDLE;
      end
    endcase
    // Commands win over a terminal-count disarm in the same cycle.
    if (disarm_cmd)
      state_next = CMD_ST_IDLE;
    if (arm_cmd)
      state_next = (is_edge && state_reg != CMD_ST_RUN) ? CMD_ST_WAIT : CMD_ST_RUN;
  end

  // Mode and load register writes, honouring byte selects.
  always_comb
  begin
    mode_next = mode_reg;
    load_next = load_reg;
    if (wr && (word == `CMD_ADR_MODE))
    begin
      if (wb_sel_i[1])
        mode_next.gate_control_field = wb_dat_i[`CMD_MODE_GATE_HI:`CMD_MODE_GATE_LO];
      if (wb_sel_i[0])
        {mode_next.special_gate_bit, mode_next.reload_source_bit,
         mode_next.repetition_bit} = wb_dat_i[`CMD_MODE_SPEC:`CMD_MODE_REP];
    end
    if (wr && (word == `CMD_ADR_LOAD))
    begin
      if (wb_sel_i[0])
        load_next[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1])
        load_next[15:8] = wb_dat_i[15:8];
    end
  end

  // Status word and read mux; unmapped words read as zero.
  always_comb
  begin
    status               = '0;
    status.armed         = state_reg != CMD_ST_IDLE;
    status.running       = state_reg == CMD_ST_RUN;
    status.at_tc         = at_tc;
    status.phase         = phase_reg;
    status.gate_level    = gate_lvl;
    status.reserved_mode = reserved;
    dat_next             = 32'h0000_0000;
    ack_next             = req;
    tc_next              = count_next == `CMD_TC_VALUE;
    if (req && !wb_we_i)
    begin
      case (word)
        `CMD_ADR_MODE:   dat_next = {16'h0000, mode_reg.gate_control_field, 5'h00,
                                     mode_reg.special_gate_bit, mode_reg.reload_source_bit,
                                     mode_reg.repetition_bit, 5'h00};
        `CMD_ADR_LOAD:   dat_next = {16'h0000, load_reg};
        `CMD_ADR_HOLD:   dat_next = {16'h0000, hold_reg};
        `CMD_ADR_COUNT:  dat_next = {16'h0000, count_reg};
        `CMD_ADR_STATUS: dat_next = {16'h0000, status};
        default:         dat_next = 32'h0000_0000;
      endcase
    end
  end

  // State registers only.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_reg  <= '0;
      state_reg <= CMD_ST_IDLE;
      load_reg  <= `CMD_WORD_RST;
      hold_reg  <= `CMD_WORD_RST;
      count_reg <= `CMD_WORD_RST;
      phase_reg <= 1'b0;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
      tc_reg    <= 1'b0;
    end
    else
    begin
      mode_reg  <= mode_next;
      state_reg <= state_next;
      load_reg  <= load_next;
      hold_reg  <= hold_next;
      count_reg <= count_next;
      phase_reg <= phase_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      tc_reg    <= tc_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign tc_o     = tc_reg;

  // Checks on the bus answer and the counting behaviour; commands are excluded where they interfere.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  bus_answer_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Wishbone answer not a single cycle after request");
  gate_free_a: assert property (state_reg == CMD_ST_RUN && !is_level && !is_edge && !reserved
      && src_rise && !at_tc && !cmd_wr |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("Ungated counter missed a source edge");
  level_block_a: assert property (is_level && !gate_lvl && !at_tc && !gate_rise && !cmd_wr
      |=> count_reg == $past(count_reg))
    else $error("Level-gated counter moved with gate inactive");
  tc_take_a: assert property (src_rise && at_tc && !gate_rise && !cmd_wr
      |=> count_reg == $past(reload_val))
    else $error("Counter at terminal count ignored a source edge");
  once_disarm_a: assert property (take && at_tc && once && !cmd_wr
      |=> state_reg == CMD_ST_IDLE)
    else $error("Single-shot mode did not disarm at terminal count");
  alt_source_a: assert property (alternate && take && at_tc && !phase_reg && !gate_rise
      && !cmd_wr |=> count_reg == $past(hold_reg) && phase_reg)
    else $error("Alternating mode did not reload from hold first");
  gate_pick_a: assert property (gate_sel && take && at_tc && !gate_rise && !cmd_wr
      |=> count_reg == ($past(gate_lvl) ? $past(hold_reg) : $past(load_reg)))
    else $error("Gate-selected reload took the wrong source");
  retrig_copy_a: assert property (retrig && state_reg != CMD_ST_IDLE && gate_rise && !reserved
      && !cmd_wr |=> hold_reg == $past(count_reg) && count_reg == $past(load_reg))
    else $error("Retrigger did not capture and reload");
  repeat_keep_a: assert property (mode_reg.repetition_bit && !is_edge && take && at_tc
      && state_reg == CMD_ST_RUN && !cmd_wr |=> state_reg == CMD_ST_RUN [*2])
    else $error("Repeating mode left the run state at terminal count");
  edge_start_a: assert property (state_reg == CMD_ST_WAIT && gate_rise && !reserved && !cmd_wr
      |=> state_reg == CMD_ST_RUN)
    else $error("Gate edge did not start an armed edge-gated counter");

  twice_done_c: cover property (twice && take && at_tc && phase_reg ##1 state_reg == CMD_ST_IDLE);
  retrig_c:     cover property (retrig && gate_rise && state_reg == CMD_ST_RUN);
  capture_c:    cover property (capture_x && gate_rise && state_reg == CMD_ST_RUN && take);

endmodule : cmd_counter_mode_decoder

// *** verification/cmd_pin_model.sv ***
// Model of the two pins that drive the counter from outside: source and gate.
// Assumes the counter samples both pins on the rising edge of clk_i through
// its own synchronisers, so every level is held for at least four clocks.
`timescale 1ns/10ps
module cmd_pin_model
(
  input  wire logic clk_i,
  output logic      source_o,
  output logic      gate_o
);

  // Both pins start low so that the counter sees no edge out of reset.
  initial
  begin
    source_o = 1'b0;
    gate_o   = 1'b0;
  end

  // Each source pulse is four clocks high and four low; shorter pulses could be
  // lost in the pin filter. The tail lets the last rise reach the count register.
  task automatic src_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      source_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      source_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask : src_pulses

  // A gate change is held long enough for the filter and the capture to settle.
  task automatic set_gate(input logic v);
    @(posedge clk_i);
    gate_o <= v;
    repeat (8) @(posedge clk_i);
  endtask : set_gate

  // One full gate pulse; only its rising side is a gate edge.
  task automatic gate_edge();
    set_gate(1'b1);
    set_gate(1'b0);
  endtask : gate_edge

endmodule : cmd_pin_model

// *** verification/test_cmd_counter_mode_decoder.sv ***
// Self-checking bench for the counter mode decoder: register bus and pins.
// Assumes the Wishbone slave answers one cycle after taking a request and
// that the pin model holds every pin level for at least four clocks.
`timescale 1ns/10ps
`include "cmd_consts.svh"
module test_cmd_counter_mode_decoder
  import cmd_pkg::*;
;
  localparam int LIMIT = 20000;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, source, gate, tc_o;
  logic [7:0]  wb_adr_i, rnd;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] rdata, ld, hd;
  int          n_errors, comparisons, cycles;

  cmd_counter_mode_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .source_i(source),
    .gate_i(gate), .tc_o(tc_o));
  cmd_pin_model drv (.clk_i(clk_i), .source_o(source), .gate_o(gate));

  // Clock at 40 MHz.
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // A hang is cut short by a cycle ceiling well above the planned run.
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: terminal flag %b, expected %b", $time, got, exp);
    end
  endtask : chk1

  // Classic single cycle; the request is held until ack is sampled high.
  // Bits the slave ignores carry random values so that decoding them is exercised.
  // Only the bench's cycle ceiling ends a wait that never sees ack.
  task automatic wb_cycle(input logic we, input logic [5:0] idx, input logic [15:0] d);
    @(posedge clk_i);
    rnd = lfsr(rnd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, rnd[1:0]};
    wb_sel_i <= {rnd[3:2], 2'h3};
    wb_dat_i <= {rnd, rnd, d};
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    rdata = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_cycle

  task automatic rd_chk(input logic [5:0] idx, input logic [15:0] exp);
    wb_cycle(1'b0, idx, 16'h0000);
    chk16(rdata, exp);
  endtask : rd_chk

  // Only the armed flag of the status word is predicted here.
  task automatic armed_chk(input logic exp);
    wb_cycle(1'b0, `CMD_ADR_STATUS, 16'h0000);
    chk16({15'h0000, rdata[0]}, {15'h0000, exp});
  endtask : armed_chk

  task automatic cmd(input int b);
    wb_cycle(1'b1, `CMD_ADR_COMMAND, 16'h0001 << b);
  endtask : cmd

  // Mode word built from the packed mode fields.
  function automatic logic [15:0] mw(input logic [2:0] g, input logic [2:0] srp);
    cmd_mode_t m;
    m = cmd_mode_t'({g, srp});
    return {m.gate_control_field, 5'h00, m.special_gate_bit, m.reload_source_bit,
            m.repetition_bit, 5'h00};
  endfunction : mw

  // Expected count after k source edges when every terminal count reloads l.
  function automatic logic [15:0] down_cnt(input logic [15:0] v, input logic [15:0] l,
                                           input int k);
    for (int i = 0; i < k; i++)
      v = (v == `CMD_TC_VALUE) ? l : v - 16'h0001;
    return v;
  endfunction : down_cnt

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Stop the counter, set a mode and both registers, then preset the count.
  task automatic prep(input logic [15:0] m, input logic [15:0] l, input logic [15:0] h);
    cmd(`CMD_BIT_DISARM);
    wb_cycle(1'b1, `CMD_ADR_MODE, m);
    wb_cycle(1'b1, `CMD_ADR_LOAD, l);
    wb_cycle(1'b1, `CMD_ADR_HOLD, h);
    cmd(`CMD_BIT_LOAD);
    rd_chk(`CMD_ADR_MODE, m);
  endtask : prep

  // Main sequence: reset values, then one scenario per group of modes.
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    rnd = 8'h2e;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_cycle(1'b1, 6'h08, 16'hffff);
    for (int i = 0; i < 9; i++)
      rd_chk(6'(i), 16'h0000);
    chk1(tc_o, 1'b0);
    repeat (3)
    begin
      rnd = lfsr(rnd);
      ld = 16'h0003 + {13'h0000, rnd[2:0]};
      prep(mw(`CMD_GATE_NONE, 3'h0), ld, 16'h00f0);
      cmd(`CMD_BIT_ARM);
      drv.src_pulses(ld - 1);
      chk1(tc_o, 1'b1);
      drv.src_pulses(1);
      rd_chk(`CMD_ADR_COUNT, ld);
      armed_chk(1'b0);
      drv.src_pulses(2);
      rd_chk(`CMD_ADR_COUNT, ld);
    end
    cmd(`CMD_BIT_ARM);
    drv.src_pulses(ld - 1);
    cmd(`CMD_BIT_DISARM);
    drv.src_pulses(1);
    rd_chk(`CMD_ADR_COUNT, ld);
    prep(mw(`CMD_GATE_NONE, 3'h1), ld, 16'h0000);
    cmd(`CMD_BIT_ARM);
    drv.set_gate(1'b1);
    drv.src_pulses(ld);
    drv.set_gate(1'b0);
    drv.src_pulses(ld + 1);
    rd_chk(`CMD_ADR_COUNT, down_cnt(ld, ld, 2 * ld + 1));
    armed_chk(1'b1);
    prep(mw(`CMD_GATE_LEVEL, 3'h0), ld, 16'h0000);
    cmd(`CMD_BIT_ARM);
    drv.src_pulses(2);
    rd_chk(`CMD_ADR_COUNT, ld);
    drv.set_gate(1'b1);
    drv.src_pulses(1);
    drv.set_gate(1'b0);
    rd_chk(`CMD_ADR_COUNT, ld - 16'h0001);
    rnd = lfsr(rnd);
    hd = 16'h0003 + {13'h0000, rnd[2:0]};
    prep(mw(`CMD_GATE_NONE, 3'h2), ld, hd);
    cmd(`CMD_BIT_ARM);
    drv.src_pulses(ld);
    rd_chk(`CMD_ADR_COUNT, hd);
    drv.src_pulses(hd);
    rd_chk(`CMD_ADR_COUNT, ld);
    armed_chk(1'b0);
    prep(mw(`CMD_GATE_EDGE, 3'h0), ld, 16'h0000);
    cmd(`CMD_BIT_ARM);
    drv.src_pulses(2);
    rd_chk(`CMD_ADR_COUNT, ld);
    drv.gate_edge();
    drv.src_pulses(ld);
    rd_chk(`CMD_ADR_COUNT, ld);
    drv.gate_edge();
    drv.src_pulses(1);
    rd_chk(`CMD_ADR_COUNT, ld);
    prep(mw(`CMD_GATE_LEVEL, 3'h4), ld, 16'h0000);
    cmd(`CMD_BIT_ARM);
    drv.set_gate(1'b1);
    drv.src_pulses(2);
    drv.set_gate(1'b0);
    drv.set_gate(1'b1);
    rd_chk(`CMD_ADR_HOLD, ld - 16'h0002);
    rd_chk(`CMD_ADR_COUNT, ld);
    drv.set_gate(1'b0);
    prep(mw(`CMD_GATE_EDGE, 3'h7), ld, 16'h0000);
    cmd(`CMD_BIT_ARM);
    drv.src_pulses(1);
    drv.gate_edge();
    drv.src_pulses(2);
    drv.gate_edge();
    rd_chk(`CMD_ADR_HOLD, ld - 16'h0002);
    rd_chk(`CMD_ADR_COUNT, ld - 16'h0002);
    prep(mw(`CMD_GATE_NONE, 3'h6), ld, hd);
    cmd(`CMD_BIT_ARM);
    drv.set_gate(1'b1);
    drv.src_pulses(ld);
    rd_chk(`CMD_ADR_COUNT, hd);
    drv.set_gate(1'b0);
    drv.src_pulses(hd);
    rd_chk(`CMD_ADR_COUNT, ld);
    armed_chk(1'b0);
    // Mode I: waits for a gate edge, then runs through both terminal counts.
    prep(mw(`CMD_GATE_EDGE, 3'h2), ld, hd);
    cmd(`CMD_BIT_ARM);
    drv.src_pulses(1);
    rd_chk(`CMD_ADR_COUNT, ld);
    drv.gate_edge();
    drv.src_pulses(ld + hd);
    rd_chk(`CMD_ADR_COUNT, ld);
    armed_chk(1'b0);
    // Mode F: stops at terminal count and needs only a new gate edge, no arm.
    prep(mw(`CMD_GATE_EDGE, 3'h1), ld, hd);
    cmd(`CMD_BIT_ARM);
    drv.gate_edge();
    drv.src_pulses(ld + 1);
    rd_chk(`CMD_ADR_COUNT, ld);
    armed_chk(1'b1);
    drv.gate_edge();
    drv.src_pulses(1);
    rd_chk(`CMD_ADR_COUNT, ld - 16'h0001);
    print_verdict();
  end

endmodule : test_cmd_counter_mode_decoder
